// >>> verilog/iorat_defs.vh
// Constants for the I/O register access bridge.
// Assumes a single core clock; slower bus rates arrive as one-cycle enables.
`ifndef IORAT_DEFS_VH
`define IORAT_DEFS_VH

`define IORAT_AW            24
`define IORAT_DW            32
`define IORAT_DIVW          4
`define IORAT_CNTW          8

// Address field that selects the internal peripheral bus.
`define IORAT_BUS_HI        18
`define IORAT_BUS_LO        16
`define IORAT_BUSW          3
// Bit that marks the bus-error registers of the external bus unit.
`define IORAT_BERR_BIT      8

`define IORAT_BUS_MAIN1     3'h0
`define IORAT_BUS_PER1      3'h1
`define IORAT_BUS_FLASH     3'h6
`define IORAT_BUS_EXT       3'h7

`define IORAT_CNT_ZERO      8'h00
`define IORAT_CNT_ONE       8'h01
`define IORAT_CNT_MAX       8'hFF

`endif

// >>> verilog/iorat_clk_div.v
// Rate divider producing a one-cycle enable every div_sel+1 core cycles.
// Assumes div_sel is static while accesses are in flight.
`timescale 1ns/1ns
`include "iorat_defs.vh"

module iorat_clk_div
(
    input  wire                     core_clk,
    input  wire                     rst,
    input  wire [`IORAT_DIVW-1:0]   div_sel,
    output reg                      en_r
);

reg  [`IORAT_DIVW-1:0] cnt_r;
wire                   wrap;

assign wrap = (cnt_r >= div_sel);

always @(posedge core_clk)
begin
    if (rst)
    begin
        cnt_r <= {`IORAT_DIVW{1'b0}};
        en_r  <= 1'b0;
    end
    else
    begin
        cnt_r <= wrap ? {`IORAT_DIVW{1'b0}} : cnt_r + {{(`IORAT_DIVW-1){1'b0}}, 1'b1};
        en_r  <= wrap;
    end
end

endmodule

// >>> verilog/iorat_bridge.v
// Bridge from the core's main bus 1 to peripheral buses 1 to 6 and the external bus unit.
// Assumes peripherals act only on their clock enable and answer with a one-enable acknowledge.
//
// Behaviour
// - Access time is main bus cycle plus synchronization plus peripheral bus cycles.
// - Peripheral portion lasts until the addressed register acknowledges, so latency varies.
// - Synchronization only for buses 2 to 6 and external unit, excluding bus-error registers.
// - Synchronization length follows clock ratio and where the access lands in the period.
// - Core not slower: main cycle plus synchronization within one peripheral or flash period.
// - Core slower than peripheral: next access starts the core cycle after completion.
// - External unit: main cycle plus synchronization within one external bus period.
// - Stated counts assume no contention; another master holding the bus delays acceptance.
`timescale 1ns/1ns
`include "iorat_defs.vh"

module iorat_bridge
(
    input  wire                     core_clk,
    input  wire                     rst,
    // Core side.
    input  wire                     cpu_req,
    input  wire                     cpu_we,
    input  wire [`IORAT_AW-1:0]     cpu_addr,
    input  wire [`IORAT_DW-1:0]     cpu_wdata,
    output reg                      cpu_ready_r,
    output reg                      cpu_done_r,
    output reg  [`IORAT_DW-1:0]     cpu_rdata_r,
    // Clock ratio settings; zero means the bus clock is not slower than the core.
    input  wire [`IORAT_DIVW-1:0]   pclk_div,
    input  wire [`IORAT_DIVW-1:0]   flash_interface_clock_div,
    input  wire [`IORAT_DIVW-1:0]   bclk_div,
    input  wire                     core_slower,
    // Contention from fetches or other bus masters.
    input  wire                     other_master_busy,
    // Peripheral side.
    output reg                      per_req_r,
    output reg                      per_we_r,
    output reg  [`IORAT_BUSW-1:0]   per_bus_r,
    output reg  [`IORAT_AW-1:0]     per_addr_r,
    output reg  [`IORAT_DW-1:0]     per_wdata_r,
    output reg                      per_en_r,
    input  wire                     per_ack,
    input  wire [`IORAT_DW-1:0]     per_rdata,
    // Observed cycle counts of the last access.
    output reg  [`IORAT_CNTW-1:0]   sync_cycles_r,
    output reg  [`IORAT_CNTW-1:0]   access_cycles_r
);

localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_MAIN = 5'h02;
localparam [4:0] ST_SYNC = 5'h04;
localparam [4:0] ST_PER  = 5'h08;
localparam [4:0] ST_RESP = 5'h10;

reg  [4:0]             state_r;
reg  [4:0]             state_nxt;
reg                    we_r;
reg  [`IORAT_AW-1:0]   addr_r;
reg  [`IORAT_DW-1:0]   wdata_r;
reg  [`IORAT_DW-1:0]   rdata_r;
reg  [`IORAT_CNTW-1:0] sync_cnt_r;
reg  [`IORAT_CNTW-1:0] acc_cnt_r;

wire                   pclk_en;
wire                   flash_interface_clock_en;
wire                   bclk_en;
wire [`IORAT_BUSW-1:0] bus_sel;
wire                   need_sync;
wire                   tgt_en;

// Field extraction used for the held address.
function [`IORAT_BUSW-1:0] bus_of;
    input [`IORAT_AW-1:0] a;
    begin
        bus_of = a[`IORAT_BUS_HI:`IORAT_BUS_LO];
    end
endfunction

// Bus 1 and the bus-error registers sit on the core rate and skip resynchronization.
function sync_of;
    input [`IORAT_AW-1:0] a;
    begin
        if (bus_of(a) == `IORAT_BUS_EXT)
            sync_of = ~a[`IORAT_BERR_BIT];
        else
            sync_of = (bus_of(a) != `IORAT_BUS_PER1) && (bus_of(a) != `IORAT_BUS_MAIN1);
    end
endfunction

// Saturating increment keeps the observed counts meaningful on long stalls.
function [`IORAT_CNTW-1:0] sat_inc;
    input [`IORAT_CNTW-1:0] c;
    begin
        sat_inc = (c == `IORAT_CNT_MAX) ? c : c + `IORAT_CNT_ONE;
    end
endfunction

iorat_clk_div u_pclk_div
(
    .core_clk (core_clk),
    .rst      (rst),
    .div_sel  (pclk_div),
    .en_r     (pclk_en)
);

iorat_clk_div u_flash_interface_clock_div
(
    .core_clk (core_clk),
    .rst      (rst),
    .div_sel  (flash_interface_clock_div),
    .en_r     (flash_interface_clock_en)
);

iorat_clk_div u_bclk_div
(
    .core_clk (core_clk),
    .rst      (rst),
    .div_sel  (bclk_div),
    .en_r     (bclk_en)
);

assign bus_sel   = bus_of(addr_r);
assign need_sync = sync_of(addr_r);

// When the core is the slower side every core edge is a valid bus edge, so no wait is inserted.
assign tgt_en = core_slower ? 1'b1 :
                (bus_sel == `IORAT_BUS_EXT)   ? bclk_en :
                (bus_sel == `IORAT_BUS_FLASH) ? flash_interface_clock_en : pclk_en;

always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE:
        begin
            if (cpu_req && !other_master_busy)
                state_nxt = ST_MAIN;
        end
        ST_MAIN:
        begin
            // The main bus cycle overlaps the wait, keeping both inside one bus period.
            if (!need_sync || tgt_en)
                state_nxt = ST_PER;
            else
                state_nxt = ST_SYNC;
        end
        ST_SYNC:
        begin
            if (tgt_en)
                state_nxt = ST_PER;
        end
        ST_PER:
        begin
            if (per_ack && (tgt_en || !need_sync))
                state_nxt = ST_RESP;
        end
        ST_RESP:
        begin
            state_nxt = ST_IDLE;
        end
        default:
        begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge core_clk)
begin
    if (rst)
    begin
        state_r         <= ST_IDLE;
        we_r            <= 1'b0;
        addr_r          <= {`IORAT_AW{1'b0}};
        wdata_r         <= {`IORAT_DW{1'b0}};
        rdata_r         <= {`IORAT_DW{1'b0}};
        sync_cnt_r      <= `IORAT_CNT_ZERO;
        acc_cnt_r       <= `IORAT_CNT_ZERO;
        cpu_ready_r     <= 1'b0;
        cpu_done_r      <= 1'b0;
        cpu_rdata_r     <= {`IORAT_DW{1'b0}};
        per_req_r       <= 1'b0;
        per_we_r        <= 1'b0;
        per_bus_r       <= {`IORAT_BUSW{1'b0}};
        per_addr_r      <= {`IORAT_AW{1'b0}};
        per_wdata_r     <= {`IORAT_DW{1'b0}};
        per_en_r        <= 1'b0;
        sync_cycles_r   <= `IORAT_CNT_ZERO;
        access_cycles_r <= `IORAT_CNT_ZERO;
    end
    else
    begin
        state_r     <= state_nxt;
        cpu_done_r  <= 1'b0;
        cpu_ready_r <= (state_nxt == ST_IDLE) && !other_master_busy;
        per_en_r    <= tgt_en;
        if (state_r == ST_IDLE && state_nxt == ST_MAIN)
        begin
            we_r       <= cpu_we;
            addr_r     <= cpu_addr;
            wdata_r    <= cpu_wdata;
            sync_cnt_r <= `IORAT_CNT_ZERO;
            acc_cnt_r  <= `IORAT_CNT_ONE;
        end
        else if (state_r != ST_IDLE && state_r != ST_RESP)
        begin
            acc_cnt_r <= sat_inc(acc_cnt_r);
        end
        if (state_r == ST_SYNC)
            sync_cnt_r <= sat_inc(sync_cnt_r);
        // The request is held until the acknowledge is taken on a bus edge.
        if (state_nxt == ST_PER)
        begin
            per_req_r   <= 1'b1;
            per_we_r    <= we_r;
            per_bus_r   <= bus_sel;
            per_addr_r  <= addr_r;
            per_wdata_r <= wdata_r;
        end
        else
        begin
            per_req_r <= 1'b0;
        end
        if (state_r == ST_PER && state_nxt == ST_RESP)
            rdata_r <= per_rdata;
        // Data reaches the core one cycle after capture so it never comes straight off the bus side.
        if (state_r == ST_RESP)
        begin
            cpu_done_r      <= 1'b1;
            cpu_rdata_r     <= we_r ? {`IORAT_DW{1'b0}} : rdata_r;
            sync_cycles_r   <= sync_cnt_r;
            access_cycles_r <= acc_cnt_r;
        end
    end
end

endmodule

// >>> verification/iorat_per_model.sv
// Peripheral register model on the far side of the bridge.
// Assumes the bench gives the latency in bus enables.
`timescale 1ns/1ns
module iorat_per_model
(
    input  wire        core_clk,
    input  wire        rst,
    input  wire        per_req_r,
    input  wire        per_en_r,
    input  wire [23:0] per_addr_r,
    input  wire [7:0]  lat,
    output wire        per_ack,
    output wire [31:0] per_rdata
);
    reg  [7:0] cnt_r;
    // The acknowledge holds as a level, since the bridge takes it only on its own enable for buses that need synchronization.
    assign per_ack = per_req_r && cnt_r == lat;
    // Idle data is inverted so that a stale word cannot pass for an answer.
    assign per_rdata = per_ack ? {8'h5A, per_addr_r} : ~{8'h5A, per_addr_r};
    always @(posedge core_clk)
    begin
        if (rst || !per_req_r)
            cnt_r <= 8'h00;
        else if (per_en_r && cnt_r != lat)
            cnt_r <= cnt_r + 8'h01;
    end
endmodule

// >>> verification/iorat_bridge_props.sv
// Checker on the bridge ports.
// Assumes a bind onto iorat_bridge.
`timescale 1ns/1ns
module iorat_bridge_props
(
    input wire        core_clk,
    input wire        rst,
    input wire        cpu_req,
    input wire        cpu_ready_r,
    input wire        cpu_done_r,
    input wire [31:0] cpu_rdata_r,
    input wire        core_slower,
    input wire        other_master_busy,
    input wire        per_req_r,
    input wire        per_ack,
    input wire [7:0]  sync_cycles_r,
    input wire [7:0]  access_cycles_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_take; cpu_ready_r && cpu_req |=> !cpu_ready_r && !per_req_r; endproperty
    a_take: assert property (p_take) else $error("bad take");
    property p_min; cpu_done_r |-> access_cycles_r >= 8'h03 && sync_cycles_r < access_cycles_r; endproperty
    a_min: assert property (p_min) else $error("short access");
    property p_hold; per_req_r && !per_ack |=> per_req_r; endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_pulse; cpu_done_r |=> !cpu_done_r; endproperty
    a_pulse: assert property (p_pulse) else $error("long done");
    property p_rdata; !cpu_done_r |-> $stable(cpu_rdata_r); endproperty
    a_rdata: assert property (p_rdata) else $error("data moved");
    property p_busy; other_master_busy |=> !cpu_ready_r; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_next; cpu_done_r && !$past(other_master_busy) |-> cpu_ready_r; endproperty
    a_next: assert property (p_next) else $error("not ready");
    property p_fast; core_slower && per_req_r && per_ack |=> !per_req_r ##1 cpu_done_r && sync_cycles_r == 8'h00;
    endproperty
    a_fast: assert property (p_fast) else $error("slow core waited");
    c_sync: cover property (cpu_done_r && sync_cycles_r != 8'h00);
    c_busy: cover property (other_master_busy && cpu_req);
    c_slow: cover property (core_slower && cpu_done_r);
endmodule
bind iorat_bridge iorat_bridge_props u_props (.core_clk, .rst, .cpu_req, .cpu_ready_r, .cpu_done_r, .cpu_rdata_r,
    .core_slower, .other_master_busy, .per_req_r, .per_ack, .sync_cycles_r, .access_cycles_r);

// >>> verification/io_register_access_timing_bench.sv
// Bench for the I/O register access bridge.
// Assumes the peripheral model answers reads with 5A above the address.
`timescale 1ns/1ns
module io_register_access_timing_bench;
    reg         core_clk = 1'b0, rst = 1'b1, cpu_req = 1'b0, cpu_we = 1'b0, core_slower = 1'b0;
    reg         other_master_busy = 1'b0;
    reg  [23:0] cpu_addr = 24'h000000;
    reg  [3:0]  pclk_div = 4'h0, flash_interface_clock_div = 4'h0, bclk_div = 4'h0;
    reg  [7:0]  lat = 8'h00, seen = 8'h00;
    wire        cpu_ready_r, cpu_done_r, per_req_r, per_we_r, per_en_r, per_ack;
    wire [31:0] cpu_rdata_r, per_rdata, per_wdata_r;
    wire [31:0] cpu_wdata;
    assign cpu_wdata = ~{8'h00, cpu_addr};
    wire [23:0] per_addr_r;
    wire [2:0]  per_bus_r;
    wire [7:0]  sync_cycles_r, access_cycles_r;
    integer     n_errors = 0, cmp_count = 0, k, n;
    iorat_bridge uut (.core_clk, .rst, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ready_r, .cpu_done_r,
        .cpu_rdata_r, .pclk_div, .flash_interface_clock_div, .bclk_div, .core_slower, .other_master_busy, .per_req_r, .per_we_r,
        .per_bus_r, .per_addr_r, .per_wdata_r, .per_en_r, .per_ack, .per_rdata, .sync_cycles_r, .access_cycles_r);
    iorat_per_model peri (.core_clk, .rst, .per_req_r, .per_en_r, .per_addr_r, .lat, .per_ack, .per_rdata);
    initial forever #25 core_clk = ~core_clk;
    task wrap_up;
        begin
            $display("errors %0d compares %0d", n_errors, cmp_count);
            if (n_errors == 0 && cmp_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task guard;
        begin
            if (n >= 60)
            begin
                n_errors = n_errors + 1;
                wrap_up;
            end
        end
    endtask
    // A reset between phases restarts the dividers at the new ratios.
    task cfg(input [3:0] p, input [3:0] f, input [3:0] b, input s);
        begin
            @(posedge core_clk);
            {rst, pclk_div, flash_interface_clock_div, bclk_div, core_slower} <= {1'b1, p, f, b, s};
            repeat (10) @(posedge core_clk);
            rst <= 1'b0;
        end
    endtask
    task access(input w, input [23:0] a, input [7:0] l, input [7:0] smax);
        begin
            @(posedge core_clk);
            {cpu_req, cpu_we, cpu_addr, lat} <= {1'b1, w, a, l};
            n = 0;
            @(negedge core_clk);
            while (cpu_ready_r !== 1'b1 && n < 60)
            begin
                @(negedge core_clk);
                n = n + 1;
            end
            guard;
            @(posedge core_clk);
            cpu_req <= 1'b0;
            // Done is first read half a cycle after the accept edge, never in that edge's own time step.
            @(negedge core_clk);
            n = 1;
            while (cpu_done_r !== 1'b1 && n < 60)
            begin
                @(negedge core_clk);
                n = n + 1;
                if (per_req_r === 1'b1)
                    chk({per_we_r, per_bus_r, per_addr_r}, {w, a[18:16], a});
                if (per_req_r === 1'b1 && w)
                    chk(per_wdata_r, ~{8'h00, a});
            end
            guard;
            if (sync_cycles_r > seen)
                seen = sync_cycles_r;
            chk(access_cycles_r, n - 1);
            chk({cpu_ready_r, sync_cycles_r <= smax}, 2'b11);
            chk(cpu_rdata_r, w ? 32'h00000000 : {8'h5A, a});
            if (smax == 8'h00)
                chk(access_cycles_r, l + 8'h03);
        end
    endtask
    task t_busy;
        begin
            @(posedge core_clk);
            other_master_busy <= 1'b1;
            @(posedge core_clk);
            cpu_req <= 1'b1;
            repeat (5) @(negedge core_clk);
            chk({cpu_ready_r, per_req_r}, 2'b00);
            // The refused request is withdrawn with the contention, so no stale command is taken.
            @(posedge core_clk);
            {other_master_busy, cpu_req} <= 2'b00;
            access(1'b0, 24'h010010, 8'h00, 8'h00);
        end
    endtask
    task t_sync;
        begin
            cfg(4'h3, 4'h1, 4'h2, 1'b0);
            for (k = 0; k < 4; k = k + 1)
            begin
                repeat (k) @(posedge core_clk);
                access(1'b0, {k[7:0] + 8'h02, 16'h0080}, 8'h01, 8'h03);
            end
            chk(seen != 8'h00, 1);
            access(1'b0, 24'h060010, 8'h00, 8'h01);
            access(1'b1, 24'h070020, 8'h00, 8'h02);
            access(1'b0, 24'h010020, 8'h00, 8'h00);
        end
    endtask
    initial
    begin
        cfg(4'h0, 4'h0, 4'h0, 1'b0);
        access(1'b0, 24'h010040, 8'h00, 8'h00);
        access(1'b0, 24'h010044, 8'h02, 8'h00);
        access(1'b1, 24'h000048, 8'h01, 8'h00);
        access(1'b0, 24'h000048, 8'h00, 8'h00);
        access(1'b1, 24'h070100, 8'h00, 8'h00);
        t_busy;
        t_sync;
        cfg(4'h0, 4'h0, 4'h0, 1'b1);
        access(1'b0, 24'h030030, 8'h01, 8'h00);
        wrap_up;
    end
endmodule
